// >>> lnb_pkg.sv
// ==========================================================================
// Shared constants and types for the local bus port.
package lnb_pkg;
  localparam int CS_NUM = 8;
  localparam int CS_IDX_W = 3;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_MHZ = 40;
  localparam int PCI_MHZ_MAX = 66;
  // The PCI clock is the internal clock divided by PCI_DIV (10 MHz here).
  localparam int PCI_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'(PCI_DIV - 1);
  localparam logic [1:0] DIV_PRE = 2'(PCI_DIV - 2);
  localparam logic [1:0] DIV_HALF = 2'(PCI_DIV / 2);
  // The other bus module may drive the pins within this many internal clocks.
  localparam int REL_IPB = 4;
  localparam int WAIT_W = 16;
  localparam int CNT_W = 17;
  localparam int BEAT_W = 5;
  // Log2 of the words per cache line: 4 to the power of the flag, times 2.
  localparam logic [2:0] WORDS_LOG_SHORT = 3'h1;
  localparam logic [2:0] WORDS_LOG_LONG = 3'h3;
  localparam logic [2:0] BEATS_LOG_FULL = 3'h2;
  localparam logic [5:0] BYTE_BITS = 6'h08;

  typedef enum logic [1:0] {
    MODE_PLAIN = 2'b00,
    MODE_FLASH = 2'b01,
    MODE_GFX = 2'b10
  } lnb_mode_t;

  typedef enum logic [1:0] {
    BW_8 = 2'b00,
    BW_16 = 2'b01,
    BW_32 = 2'b10
  } lnb_width_t;

  typedef struct packed {
    logic [7:0] wait_field_extra;
    logic [7:0] wait_field_primary;
    logic [7:0] dead_count;
    lnb_width_t bus_width;
    lnb_mode_t mode;
    logic burst_enable_bit;
    logic long_burst_enable_bit;
  } lnb_cs_cfg_t;

  typedef struct packed {
    logic [CS_IDX_W-1:0] cs;
    logic read;
    logic sys_burst;
    logic [1:0] size;
    logic [ADDR_W-1:0] addr;
  } lnb_req_t;

  typedef struct packed {
    logic pci_clk;
    logic [CS_NUM-1:0] cs_n;
    logic ts_n;
    logic rw;
    logic oe_n;
    logic [1:0] xfer_size;
    logic [ADDR_W-1:0] addr;
    logic addr_oe_n;
    logic data_oe_n;
    logic ack;
    logic ack_oe_n;
  } lnb_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_WAIT = 3'b010,
    ST_DATA = 3'b011,
    ST_HOLD = 3'b100,
    ST_DEAD = 3'b101
  } lnb_state_t;
endpackage

// >>> lnb_port.sv
// Summary of operation
// - Wait count per chip select joins two config fields, any value 0 to 65535.
// - In single-beat mode acknowledge is an input that may end the pulse early.
// - Start strobe of one PCI clock precedes select in flash or graphics mode and in any burst.
// - Size outputs only in graphics mode, valid around the select pulse.
// - In flash and graphics modes address pins release together with select.
// - After select negates, keep bus for dead cycles unless another module wins.
// - On hand-over to another bus module, skip dead cycles and release quickly.
// - Burst select lasts one plus wait plus cache line beats PCI clocks.
// - Burst acknowledge is an output lasting the cache line beats.
// - Long burst only when burst and long bits set and system bus bursts.
// - Burst acknowledge asserts within wait plus one PCI clocks of select.
// - Burst acknowledge negates before select negates.
// - Each burst beat passes on a rising PCI clock edge, held through it.
// - Burst issues a one PCI clock start strobe, select follows it.
// - Direction valid one PCI clock before select and held one after.
// - Single reads capture data as select negates; slave holds it until then.
// - Eight chip selects; bus timing referenced to the PCI clock.
`timescale 1ns/1ps

// ==========================================================================
// Write data FIFO.
module lnb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0] cnt_q;
  logic [PTR_W:0] cnt_d;
  logic push;
  logic pop;

  // Ready is registered so the source never sees a combinational path.
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_ptr_q];
  assign level = cnt_q;
  assign cnt_d = cnt_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);

  // Storage needs no reset; only occupied words are ever read.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q + PTR_W'(push);
      rd_ptr_q <= rd_ptr_q + PTR_W'(pop);
      cnt_q <= cnt_d;
      in_ready <= cnt_d < (PTR_W+1)'(DEPTH);
    end
  end
endmodule

// ==========================================================================
// Local bus port, non-multiplexed single-beat and burst transfers.
module lnb_port
  import lnb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input lnb_cs_cfg_t [CS_NUM-1:0] cs_cfg,
  input wire logic req_valid,
  input lnb_req_t req,
  output logic req_ready,
  input wire logic wr_valid,
  input wire logic [DATA_W-1:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  input wire logic other_grant,
  output logic bus_own,
  output lnb_pins_t pins,
  output logic [DATA_W-1:0] data_out,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic ack_in
);
  lnb_state_t st_q;
  lnb_state_t st_d;
  lnb_req_t cur_q;
  lnb_cs_cfg_t cfg_q;
  lnb_cs_cfg_t new_cfg;
  logic [1:0] div_q;
  logic tick;
  logic pre_tick;
  logic [CNT_W-1:0] cnt_q;
  logic [BEAT_W-1:0] beat_q;
  logic [BEAT_W-1:0] last_beat_q;
  logic [1:0] mask_q;
  logic burst_q;
  logic long_q;
  logic ack_seen_q;
  logic new_burst;
  logic new_long;
  logic start;
  logic pop;
  logic fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic [WAIT_W-1:0] wait_count;
  logic cs_any;
  logic last_beat;

  // Shift of a beat count: words per line plus beats per word, both as logs.
  function automatic logic [2:0] beat_log(input lnb_width_t w, input logic lng);
    beat_log = (lng ? WORDS_LOG_LONG : WORDS_LOG_SHORT) + (BEATS_LOG_FULL - 3'(w));
  endfunction

  // ========================================================================
  // Request decode.
  assign new_cfg = cs_cfg[req.cs];
  assign new_burst = new_cfg.burst_enable_bit && req.sys_burst;
  assign new_long = new_burst && new_cfg.long_burst_enable_bit;
  assign wait_count = {cfg_q.wait_field_extra, cfg_q.wait_field_primary};
  assign tick = div_q == DIV_LAST;
  assign pre_tick = div_q == DIV_PRE;
  assign cs_any = pins.cs_n != '1;
  assign last_beat = beat_q == last_beat_q;
  // A write starts only when all its words are buffered: the whole line for a burst, one word for a single beat.
  assign start = tick && st_q == ST_IDLE && req_valid && req_ready && !other_grant
      && (req.read || fifo_level >= ($clog2(FIFO_DEPTH)+1)'(new_burst
      ? (5'h01 << (new_long ? WORDS_LOG_LONG : WORDS_LOG_SHORT)) : 5'h01));

  // ========================================================================
  // PCI clock divider; every sequencing step but the hand-over exit from ST_DEAD waits for the tick.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? 2'h0 : div_q + 2'h1;
    end
  end

  // ========================================================================
  // Transfer sequencer.
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (start) begin
          st_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tick) begin
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (tick && burst_q && cnt_q == {1'b0, wait_count}) begin
          st_d = ST_DATA;
        end else if (tick && !burst_q
            && (ack_seen_q || cnt_q == {1'b0, wait_count} + 17'h0_0001)) begin
          st_d = ST_HOLD;
        end
      end
      ST_DATA: begin
        if (tick && last_beat) begin
          st_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tick) begin
          st_d = cfg_q.dead_count == '0 ? ST_IDLE : ST_DEAD;
        end
      end
      ST_DEAD: begin
        if (other_grant) begin
          st_d = ST_IDLE;
        end else if (tick && cnt_q[7:0] == cfg_q.dead_count - 8'h01) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      req_ready <= 1'b0;
      bus_own <= 1'b0;
    end else begin
      st_q <= st_d;
      req_ready <= st_d == ST_IDLE;
      bus_own <= st_d != ST_IDLE;
    end
  end

  // Request latch taken at the start of a transfer.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur_q <= '0;
      cfg_q <= '0;
      burst_q <= 1'b0;
      long_q <= 1'b0;
      last_beat_q <= '0;
      mask_q <= '0;
    end else if (start) begin
      cur_q <= req;
      cfg_q <= new_cfg;
      burst_q <= new_burst;
      long_q <= new_long;
      last_beat_q <= new_burst ? BEAT_W'((6'h01 << beat_log(new_cfg.bus_width, new_long))
          - 6'h01) : '0;
      mask_q <= 2'((3'h1 << (BEATS_LOG_FULL - 3'(new_cfg.bus_width))) - 3'h1);
    end
  end

  // Wait, dead and beat counters, plus the sampled slave acknowledge.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
      beat_q <= '0;
      ack_seen_q <= 1'b0;
    end else begin
      if (st_d != st_q) begin
        cnt_q <= '0;
      end else if (tick) begin
        cnt_q <= cnt_q + 17'h0_0001;
      end
      if (st_q != ST_DATA) begin
        beat_q <= '0;
      end else if (tick) begin
        beat_q <= beat_q + 5'h01;
      end
      // Only single-beat transfers listen; a burst drives this line itself.
      if (start) begin
        ack_seen_q <= 1'b0;
      end else if (tick && st_q == ST_WAIT && !burst_q && ack_in) begin
        ack_seen_q <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Pin drivers.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pins <= '{pci_clk: 1'b0, cs_n: '1, ts_n: 1'b1, rw: 1'b1, oe_n: 1'b1,
          xfer_size: 2'h0, addr: '0, addr_oe_n: 1'b1, data_oe_n: 1'b1,
          ack: 1'b0, ack_oe_n: 1'b1};
    end else begin
      pins.pci_clk <= div_q < DIV_HALF;
      if (start) begin
        pins.ts_n <= !(new_burst || new_cfg.mode != MODE_PLAIN);
        pins.rw <= req.read;
        pins.addr <= req.addr;
        pins.addr_oe_n <= 1'b0;
        pins.data_oe_n <= req.read;
        pins.xfer_size <= new_cfg.mode == MODE_GFX ? req.size : 2'h0;
      end else if (st_q == ST_SETUP && tick) begin
        pins.ts_n <= 1'b1;
        pins.cs_n <= ~(CS_NUM'(1) << cur_q.cs);
        pins.oe_n <= !cur_q.read;
      end else if (st_d == ST_HOLD && st_q != ST_HOLD) begin
        pins.cs_n <= '1;
        pins.oe_n <= 1'b1;
        if (cfg_q.mode != MODE_PLAIN) begin
          pins.addr_oe_n <= 1'b1;
        end
      end else if (st_q == ST_HOLD && tick) begin
        pins.addr_oe_n <= 1'b1;
        pins.data_oe_n <= 1'b1;
        pins.xfer_size <= 2'h0;
      end
      // Acknowledge drops one internal clock before select so it negates first.
      pins.ack <= st_d == ST_DATA && !(last_beat && (pre_tick || tick));
      pins.ack_oe_n <= !(burst_q && (st_d == ST_WAIT || st_d == ST_DATA));
    end
  end

  // ========================================================================
  // Data path: write words shift out a beat at a time, reads are captured.
  assign pop = fifo_valid && ((start && !req.read) || (st_q == ST_DATA && tick
      && !cur_q.read && (beat_q[1:0] & mask_q) == mask_q && !last_beat));

  lnb_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data),
    .level(fifo_level)
  );

  // The next word loads before the beat edge so it is held through it.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_out <= '0;
    end else if (pop) begin
      data_out <= fifo_data;
    end else if (st_q == ST_DATA && tick && !cur_q.read && !last_beat) begin
      // The last beat keeps its word so the data holds past select negation.
      data_out <= data_out >> (BYTE_BITS << cfg_q.bus_width);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= cur_q.read && ((st_q == ST_DATA && tick)
          || (st_q == ST_WAIT && st_d == ST_HOLD));
      rd_data <= data_in;
    end
  end

  // ========================================================================
  // Checks. Helper counters measure select and acknowledge lengths.
  logic [23:0] cs_len_q;
  logic [23:0] ack_len_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cs_len_q <= '0;
      ack_len_q <= '0;
    end else begin
      cs_len_q <= cs_any ? cs_len_q + 24'h00_0001 : '0;
      ack_len_q <= pins.ack ? ack_len_q + 24'h00_0001 : '0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_ts_pulse;
    (!pins.ts_n)[*4] ##1 (pins.ts_n && cs_any);
  endsequence
  sequence s_cs_end;
    cs_any ##1 !cs_any;
  endsequence

  a_ts_then_cs: assert property ($fell(pins.ts_n) |-> s_ts_pulse)
    else $error("start strobe width or select order wrong");
  a_ts_mode_gate: assert property (!pins.ts_n |-> burst_q || cfg_q.mode != MODE_PLAIN)
    else $error("start strobe in plain single-beat mode");
  a_cs_width_exact: assert property ($rose(&pins.cs_n) && !ack_seen_q |->
      int'(cs_len_q) == (burst_q ? 1 + int'(wait_count) + int'(last_beat_q) + 1
      : 2 + int'(wait_count)) * PCI_DIV)
    else $error("select pulse width wrong");
  a_ack_deadline: assert property ($rose(pins.ack) |->
      int'(cs_len_q) <= (int'(wait_count) + 1) * PCI_DIV)
    else $error("burst acknowledge late");
  a_ack_width: assert property ($fell(pins.ack) |->
      int'(ack_len_q) == (int'(last_beat_q) + 1) * PCI_DIV - 1)
    else $error("burst acknowledge width wrong");
  a_ack_before_cs: assert property ($fell(pins.ack) |-> s_cs_end)
    else $error("acknowledge did not negate before select");
  a_rw_hold_after: assert property ($rose(&pins.cs_n) |-> ($stable(pins.rw))[*4])
    else $error("direction changed within a PCI clock of select negation");
  a_size_gfx_only: assert property (pins.xfer_size != 2'h0 |-> cfg_q.mode == MODE_GFX)
    else $error("size outputs driven outside graphics mode");
  a_addr_release: assert property ($rose(&pins.cs_n) && cfg_q.mode != MODE_PLAIN
      |-> pins.addr_oe_n)
    else $error("address not released with select");
  a_dead_skip: assert property (st_q == ST_DEAD && other_grant |=> !bus_own)
    else $error("bus not released on hand-over");
  a_ack_ends_cs: assert property (ack_seen_q && tick && st_q == ST_WAIT
      |=> !cs_any)
    else $error("select not ended after slave acknowledge");
  a_long_flag: assert property (long_q |-> burst_q && cfg_q.long_burst_enable_bit)
    else $error("long burst without its enables");
endmodule

// >>> lnb_slave.sv
`timescale 1ns/1ps

// ====================
// Memory on the chip selects: acks single beats late or never, serves reads.
module lnb_slave
  import lnb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input lnb_pins_t pins,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic [3:0] ack_after,
  input wire logic [DATA_W-1:0] rd_word,
  output logic [DATA_W-1:0] data_in,
  output logic ack_drv,
  output logic [DATA_W-1:0] wr_seen
);
  logic pci_q;
  logic sel_q;
  logic [3:0] tick_q;
  logic [DATA_W-1:0] last_q;
  logic sel;

  // Read data stays put for the whole pulse; a released bus shows the inverse
  // of its last value, so a capture outside the pulse cannot match by luck.
  assign sel = ~&pins.cs_n;
  assign data_in = (sel && pins.rw) ? rd_word : ~last_q;

  // Acknowledge waits at least one PCI clock into the pulse, drops on the first
  // PCI edge without a select, and is never driven while the port drives it.
  always_ff @(posedge sys_clk) begin
    pci_q <= pins.pci_clk;
    sel_q <= sel;
    last_q <= data_in;
    if (sys_rst) begin
      ack_drv <= 1'b0;
      tick_q <= 4'h0;
    end else if (pins.pci_clk && !pci_q) begin
      if (!sel) begin
        ack_drv <= 1'b0;
        tick_q <= 4'h0;
      end else begin
        tick_q <= tick_q + ((tick_q != 4'hf) ? 4'h1 : 4'h0);
        if (ack_after != 4'h0 && tick_q >= ack_after && pins.ack_oe_n) begin
          ack_drv <= 1'b1;
        end
      end
    end
  end

  // Write data is taken just after the select negates, inside its hold time.
  always_ff @(posedge sys_clk) begin
    if (sel_q && !sel && !pins.rw) begin
      wr_seen <= data_out;
    end
  end
endmodule

// >>> lnb_port_tb.sv
`timescale 1ns/1ps

// ====================
// Self-checking bench for the local bus port.
module lnb_port_tb
  import lnb_pkg::*;
;
  localparam int LIMIT = 20000;
  localparam logic [31:0] RD_WORD = 32'ha5c3_1e07;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  lnb_cs_cfg_t [CS_NUM-1:0] cs_cfg = '0;
  logic req_valid = 1'b0;
  lnb_req_t req = '0;
  logic req_ready;
  logic wr_valid = 1'b0;
  logic [DATA_W-1:0] wr_data = '0;
  logic wr_ready;
  logic rd_valid;
  logic [DATA_W-1:0] rd_data;
  logic other_grant = 1'b0;
  logic bus_own;
  lnb_pins_t pins;
  logic [DATA_W-1:0] data_out;
  logic [DATA_W-1:0] data_in;
  logic ack_drv;
  logic ack_line;
  logic [3:0] ack_after = 4'h0;
  logic [DATA_W-1:0] wr_seen;
  logic [1:0] exp_sz = 2'b00;
  logic exp_rw = 1'b1;
  int fail_count;
  int comparisons;
  int cyc;
  int cur_cs;
  int cs_cyc, ts_cyc, ts_pre, ack_cyc, first_ack, rdv, rd_bad, size_bad, rw_bad, post_cs;
  bit ok;

  // Clock, and the acknowledge wire shared by the port and the memory.
  always #12.5 sys_clk = ~sys_clk;
  assign ack_line = pins.ack_oe_n ? ack_drv : pins.ack;

  lnb_port dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cs_cfg(cs_cfg), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .other_grant(other_grant), .bus_own(bus_own), .pins(pins), .data_out(data_out),
    .data_in(data_in), .ack_in(ack_line)
  );

  lnb_slave slave (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .pins(pins), .data_out(data_out),
    .ack_after(ack_after), .rd_word(RD_WORD), .data_in(data_in), .ack_drv(ack_drv),
    .wr_seen(wr_seen)
  );

  // Pin monitor: counts select, strobe and acknowledge cycles of one transfer.
  always @(posedge sys_clk) begin
    if (pins.cs_n[cur_cs] === 1'b0) begin
      if (pins.ack === 1'b1 && first_ack < 0) first_ack = cs_cyc;
      cs_cyc++;
      if (pins.xfer_size !== exp_sz) size_bad++;
      if (pins.rw !== exp_rw) rw_bad++;
      if (pins.addr !== 32'h0000_1000) rw_bad++;
    end else if (cs_cyc > 0 && bus_own === 1'b1) begin
      post_cs++;
    end
    if (pins.ts_n === 1'b0) begin
      ts_cyc++;
      if (cs_cyc == 0) ts_pre++;
    end
    if (pins.ack === 1'b1) ack_cyc++;
    if (rd_valid === 1'b1) begin
      rdv++;
      if (rd_data !== RD_WORD) rd_bad++;
    end
    cyc++;
    if (cyc > LIMIT) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ====================
  // Shared tasks.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic set_cfg(input int cs, input lnb_mode_t m, input logic [15:0] ws,
                         input logic [7:0] dc, input lnb_width_t bw, input logic be,
                         input logic lb);
    cs_cfg[cs] = '{wait_field_extra: ws[15:8], wait_field_primary: ws[7:0],
                   dead_count: dc, bus_width: bw, mode: m, burst_enable_bit: be,
                   long_burst_enable_bit: lb};
  endtask

  // Called at a falling edge with wr_valid already high; leaves it high.
  task automatic push(input logic [31:0] w, output bit took);
    int n;
    n = 0;
    wr_data = w;
    while (wr_ready !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    took = (wr_ready === 1'b1);
    @(negedge sys_clk);
  endtask

  // One request, held until taken, then waited on until the port is idle.
  task automatic xfer(input int cs, input logic rd, input logic sb, input logic [1:0] sz);
    int n;
    cur_cs = cs;
    {cs_cyc, ts_cyc, ts_pre, ack_cyc, rdv, rd_bad, size_bad, rw_bad, post_cs} = '0;
    first_ack = -1;
    exp_rw = rd;
    exp_sz = (cs_cfg[cs].mode == MODE_GFX) ? sz : 2'b00;
    req = '{cs: 3'(cs), read: rd, sys_burst: sb, size: sz, addr: 32'h0000_1000};
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b0 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    req_valid = 1'b0;
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(32'(n < 3000), 1, "transfer done");
  endtask

  task automatic t_burst(input int cs, input lnb_width_t bw, input logic lb, input logic rd,
                         input logic [15:0] ws, input int beats);
    set_cfg(cs, MODE_PLAIN, ws, 8'h00, bw, 1'b1, lb);
    xfer(cs, rd, 1'b1, 2'b00);
    chk(cs_cyc, (1 + ws + beats) * 4, "burst select");
    chk(ack_cyc, beats * 4 - 1, "burst ack");
    chk(first_ack, (ws + 1) * 4, "ack delay");
    chk(ts_pre, 4, "start strobe");
    chk(rw_bad, 0, "direction");
    chk(rdv, rd ? beats : 0, "beats read");
    chk(rd_bad, 0, "read data");
  endtask

  // ====================
  // Scenarios.
  task automatic t_modes();
    lnb_mode_t m;
    for (int i = 0; i < 3; i++) begin
      m = lnb_mode_t'(i);
      set_cfg(i, m, 16'h0001, 8'h00, BW_32, 1'b0, 1'b0);
      xfer(i, 1'b1, 1'b0, 2'b11);
      chk(cs_cyc, 12, "single pulse");
      chk(ts_cyc, (m == MODE_PLAIN) ? 0 : 4, "strobe width");
      chk(ts_pre, ts_cyc, "strobe first");
      chk(size_bad, 0, "size lines");
      chk(rdv + rd_bad, 1, "read capture");
    end
  endtask

  task automatic t_single();
    wr_valid = 1'b1;
    push(32'h1234_5678, ok);
    wr_valid = 1'b0;
    set_cfg(3, MODE_PLAIN, 16'h0000, 8'h00, BW_32, 1'b0, 1'b0);
    xfer(3, 1'b0, 1'b0, 2'b00);
    chk(cs_cyc, 8, "write pulse");
    chk(rw_bad, 0, "write direction");
    chk(wr_seen, 32'h1234_5678, "write data");
    ack_after = 4'h1;
    set_cfg(4, MODE_PLAIN, 16'h0014, 8'h00, BW_32, 1'b0, 1'b0);
    xfer(4, 1'b1, 1'b0, 2'b00);
    chk(32'(cs_cyc >= 8 && cs_cyc <= 16), 1, "ack cut");
    chk(rdv + rd_bad, 1, "ack read");
    ack_after = 4'h0;
    set_cfg(6, MODE_PLAIN, 16'h0102, 8'h00, BW_32, 1'b1, 1'b1);
    xfer(6, 1'b1, 1'b0, 2'b00);
    chk(cs_cyc, 1040, "long wait");
    set_cfg(6, MODE_PLAIN, 16'h0000, 8'h00, BW_32, 1'b0, 1'b1);
    xfer(6, 1'b1, 1'b1, 2'b00);
    chk(cs_cyc, 8, "no burst");
  endtask

  task automatic t_dead();
    set_cfg(7, MODE_PLAIN, 16'h0000, 8'h03, BW_32, 1'b0, 1'b0);
    xfer(7, 1'b1, 1'b0, 2'b00);
    chk(32'(post_cs >= 15 && post_cs <= 17), 1, "dead cycles");
    set_cfg(5, MODE_PLAIN, 16'h0000, 8'd200, BW_32, 1'b0, 1'b0);
    post_cs = 0;
    fork
      xfer(5, 1'b1, 1'b0, 2'b00);
      begin
        while (post_cs < 6) @(negedge sys_clk);
        other_grant = 1'b1;
      end
    join
    chk(32'(post_cs <= 7 + REL_IPB), 1, "hand over");
    fork
      xfer(5, 1'b1, 1'b0, 2'b00);
      begin
        repeat (12) @(negedge sys_clk);
        chk(cs_cyc, 0, "refused while granted");
        other_grant = 1'b0;
      end
    join
    chk(cs_cyc, 8, "after grant");
  endtask

  task automatic t_fifo();
    wr_valid = 1'b1;
    for (int i = 0; i < 16; i++) begin
      push(32'h0bad_0000 + i, ok);
      chk(ok, 1, "fifo accept");
    end
    push(32'hffff_ffff, ok);
    wr_valid = 1'b0;
    chk(ok, 0, "fifo full");
    t_burst(2, BW_32, 1'b1, 1'b0, 16'h0000, 8);
    t_burst(2, BW_32, 1'b1, 1'b0, 16'h0000, 8);
    chk(wr_ready, 1, "fifo drained");
  endtask

  // ====================
  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (16) @(negedge sys_clk);
    chk(pins.cs_n, 32'h0000_00ff, "reset selects");
    chk({bus_own, req_ready, pins.ack_oe_n}, 32'h0000_0001, "reset state");
    sys_rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({req_ready, wr_ready}, 32'h0000_0003, "ready after reset");
    t_modes();
    t_single();
    wr_valid = 1'b1;
    push(32'hc0de_0001, ok);
    push(32'hc0de_0002, ok);
    wr_valid = 1'b0;
    t_burst(1, BW_32, 1'b0, 1'b0, 16'h0001, 2);
    chk(wr_seen, 32'hc0de_0002, "burst write");
    t_burst(2, BW_8, 1'b1, 1'b1, 16'h0000, 32);
    t_burst(3, BW_16, 1'b0, 1'b1, 16'h0002, 4);
    t_dead();
    t_fifo();
    tally_and_finish();
  end
endmodule
